//--- src/bcr_consts.svh
// How it works
// - BCD calendar, subsecond to year, 12/24h.
// - Date rolls over at true month length.
// - Shift adds or masks 1..32767 clock pulses.
// - 50/60 Hz reference may drive seconds.
// - Smooth calibration in 0.95 ppm steps.
// - Filtered tamper pin flags tamper events.
// - Pin, tamper or battery switch captures timestamp.
// - 17-bit auto-reload periodic wake-up timer.
// - Twenty 32-bit backup registers.
// - Backup registers ignore every reset.
// - Clock from crystal, two RCs, or fast clock/32.
// - Only crystal source runs in battery/shutdown.
// - Every event can interrupt and wake.
`ifndef BCR_CONSTS_SVH
`define BCR_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define BCR_OFF_TIME   8'h00
`define BCR_OFF_DATE   8'h04
`define BCR_OFF_CTRL   8'h08
`define BCR_OFF_PRESC  8'h0C
`define BCR_OFF_WUTR   8'h10
`define BCR_OFF_ALRA   8'h14
`define BCR_OFF_ALRB   8'h18
`define BCR_OFF_SSR    8'h1C
`define BCR_OFF_SHIFT  8'h20
`define BCR_OFF_CAL    8'h24
`define BCR_OFF_STAT   8'h28
`define BCR_OFF_MASK   8'h2C
`define BCR_OFF_TSTIME 8'h30
`define BCR_OFF_TSDATE 8'h34
`define BCR_OFF_TSSSR  8'h38
`define BCR_OFF_BKP    8'h80
// ==========================================================
// Control field positions
`define BCR_CT_FMT12   0
`define BCR_CT_REFON   1
`define BCR_CT_REF60   2
`define BCR_CT_WUTE    3
`define BCR_CT_WUCK    4
`define BCR_CT_CLKSEL  7
`define BCR_CT_TSFALL  9
`define BCR_CT_TPOL    10
`define BCR_CT_TFLT    11
`define BCR_CT_TAMPTS  13
`define BCR_CT_ALRAE   14
`define BCR_CT_ALRBE   15
`define BCR_CT_TSE     16
`define BCR_CT_TAMPE   17
// ==========================================================
// Event bit positions in status and mask
`define BCR_EV_ALRA    0
`define BCR_EV_ALRB    1
`define BCR_EV_WAKE    2
`define BCR_EV_TS      3
`define BCR_EV_TSOVF   4
`define BCR_EV_TAMP    5
// ==========================================================
// Synchronised pin positions
`define BCR_PIN_XTAL   0
`define BCR_PIN_RCA    1
`define BCR_PIN_RCB    2
`define BCR_PIN_FAST   3
`define BCR_PIN_REF    4
`define BCR_PIN_TAMP   5
`define BCR_PIN_TS     6
`define BCR_PIN_VBAT   7
`define BCR_PIN_SHDN   8
// ==========================================================
// Reset values and timing counts
`define BCR_RST_APRE   7'h7F
`define BCR_RST_SPRE   15'h00FF
`define BCR_RST_DAY    8'h01
`define BCR_RST_MON    8'h01
`define BCR_RST_WDAY   3'h1
`define BCR_RST_CTRL   18'h0_0000
`define BCR_RST_WUTR   16'hFFFF
`define BCR_REF50_TOP  6'h31
`define BCR_REF60_TOP  6'h3B
`define BCR_REF_AGE    5'h10
`define BCR_CAL_SLOT   11
`define BCR_FAST_DIV   5'h1F
`endif

//--- src/bcr_pkg.sv
// ==========================================================
// Types shared by the calendar block
package bcr_pkg;
    typedef enum logic [1:0] {
        BCR_SRC_XTAL = 2'b00,
        BCR_SRC_RCA  = 2'b01,
        BCR_SRC_RCB  = 2'b10,
        BCR_SRC_FAST = 2'b11
    } bcr_src_t;
    typedef logic [5:0] bcr_ev_t;
endpackage : bcr_pkg

//--- src/bcr_top.sv
`timescale 1ns/1ps
`include "bcr_consts.svh"
module bcr_top
    import bcr_pkg::*;
#(
    parameter int NUM_BKP = 20
)(
    input  logic        hclk,
    input  logic        hresetn,
    input  logic        ce,
    input  logic        hsel,
    input  logic [31:0] haddr,
    input  logic [1:0]  htrans,
    input  logic        hwrite,
    input  logic [2:0]  hsize,
    input  logic [31:0] hwdata,
    input  logic        hready,
    output logic        hreadyout,
    output logic [31:0] hrdata,
    output logic        hresp,
    input  logic        low_speed_crystal_clock,
    input  logic        low_power_rc_clock_a,
    input  logic        low_drift_rc_clock_b,
    input  logic        high_speed_external_clock,
    input  logic        ref_clock_in,
    input  logic        tamper_in,
    input  logic        timestamp_in,
    input  logic        battery_mode,
    input  logic        shutdown_mode,
    output logic        irq,
    output logic        wakeup
);
    if (NUM_BKP < 1 || NUM_BKP > 32) begin : g_chk
        $error("NUM_BKP must lie in 1..32");
    end

    // ==========================================================
    // Helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc
    function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        if (m == 8'h02)
            month_len = leap ? 8'h29 : 8'h28;
        else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
            month_len = 8'h30;
        else
            month_len = 8'h31;
    endfunction : month_len
    function automatic logic [31:0] pack_time(input logic [7:0] s, input logic [7:0] mi,
                                              input logic [7:0] h, input logic p);
        pack_time = {9'h000, p, h[5:0], 1'b0, mi[6:0], 1'b0, s[6:0]};
    endfunction : pack_time
    function automatic logic [31:0] pack_date(input logic [7:0] y, input logic [2:0] w,
                                              input logic [7:0] m, input logic [7:0] d);
        pack_date = {8'h00, y, w, m[4:0], 2'b00, d[5:0]};
    endfunction : pack_date
    function automatic logic alarm_hit(input logic [31:0] a, input logic [31:0] t,
                                       input logic [7:0] d);
        alarm_hit = (a[7] | (a[6:0] == t[6:0])) & (a[15] | (a[14:8] == t[14:8]))
                  & (a[23] | (a[22:16] == t[22:16])) & (a[31] | (a[29:24] == d[5:0]));
    endfunction : alarm_hit

    // ==========================================================
    // AHB-Lite slave: one wait state on every word transfer
    logic        ph_q, w_q, v_q, rdy_q, resp_q;
    logic [7:0]  a_q;
    logic [31:0] rd_q, rd_mux;
    wire acc  = hsel & htrans[1] & hready & (hsize == 3'b010);
    wire wr   = ph_q & w_q & v_q;
    wire rd   = ph_q & ~w_q & v_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) begin
            ph_q <= 1'b0; w_q <= 1'b0; v_q <= 1'b0; a_q <= 8'h00;
            rdy_q <= 1'b1; resp_q <= 1'b0; rd_q <= 32'h0000_0000;
        end else if (ce) begin
            if (acc) begin
                ph_q <= 1'b1; rdy_q <= 1'b0; w_q <= hwrite;
                a_q <= haddr[7:0]; v_q <= (haddr[31:8] == 24'h00_0000);
            end else if (ph_q) begin
                ph_q <= 1'b0; rdy_q <= 1'b1;
                rd_q <= w_q ? 32'h0000_0000 : rd_mux;
            end
        end
    end
    assign hreadyout = rdy_q;
    assign hrdata    = rd_q;
    assign hresp     = resp_q;
    wire bkp_sel  = a_q[7] & (32'(a_q[6:2]) < NUM_BKP);
    wire wr_time  = wr & (a_q == `BCR_OFF_TIME);
    wire wr_date  = wr & (a_q == `BCR_OFF_DATE);
    wire wr_ctrl  = wr & (a_q == `BCR_OFF_CTRL);
    wire wr_presc = wr & (a_q == `BCR_OFF_PRESC);
    wire wr_wutr  = wr & (a_q == `BCR_OFF_WUTR);
    wire wr_alra  = wr & (a_q == `BCR_OFF_ALRA);
    wire wr_alrb  = wr & (a_q == `BCR_OFF_ALRB);
    wire wr_shift = wr & (a_q == `BCR_OFF_SHIFT);
    wire wr_cal   = wr & (a_q == `BCR_OFF_CAL);
    wire wr_mask  = wr & (a_q == `BCR_OFF_MASK);
    wire wr_bkp   = wr & bkp_sel;
    wire rd_stat  = rd & (a_q == `BCR_OFF_STAT);

    // ==========================================================
    // Software registers
    logic [17:0] ctl_q;
    logic [15:0] wutr_q;
    logic [31:0] alra_q, alrb_q;
    logic        calp_q;
    logic [8:0]  calm_q;
    bcr_ev_t     msk_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) begin
            ctl_q <= `BCR_RST_CTRL; wutr_q <= `BCR_RST_WUTR; alra_q <= 32'h0000_0000;
            alrb_q <= 32'h0000_0000; calp_q <= 1'b0; calm_q <= 9'h000; msk_q <= '0;
        end else if (ce) begin
            if (wr_ctrl) ctl_q <= hwdata[17:0];
            if (wr_wutr) wutr_q <= hwdata[15:0];
            if (wr_alra) alra_q <= hwdata;
            if (wr_alrb) alrb_q <= hwdata;
            if (wr_cal) begin calp_q <= hwdata[15]; calm_q <= hwdata[8:0]; end
            if (wr_mask) msk_q <= hwdata[5:0];
        end
    end
    wire       fmt12  = ctl_q[`BCR_CT_FMT12];
    wire [2:0] wuck   = ctl_q[`BCR_CT_WUCK +: 3];
    wire [1:0] tflt   = ctl_q[`BCR_CT_TFLT +: 2];
    bcr_src_t  clksel;
    assign clksel = bcr_src_t'(ctl_q[`BCR_CT_CLKSEL +: 2]);

    // Backup words carry no reset so their contents outlive every reset.
    logic [31:0] bkp_mem [NUM_BKP];
    always_ff @(posedge hclk)
    begin
        if (ce && wr_bkp) bkp_mem[a_q[6:2]] <= hwdata;
    end

    // ==========================================================
    // Pin synchronisers; only the second and third stages are ever read
    logic [8:0] s1_q, s2_q, s3_q;
    wire  [8:0] pins = {shutdown_mode, battery_mode, timestamp_in, tamper_in, ref_clock_in,
                        high_speed_external_clock, low_drift_rc_clock_b,
                        low_power_rc_clock_a, low_speed_crystal_clock};
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) begin
            s1_q <= 9'h000; s2_q <= 9'h000; s3_q <= 9'h000;
        end else if (ce) begin
            s1_q <= pins; s2_q <= s1_q; s3_q <= s2_q;
        end
    end
    wire [8:0] rise = s2_q & ~s3_q;
    wire [8:0] fall = ~s2_q & s3_q;

    // ==========================================================
    // Clock source, smooth calibration and shift
    logic [4:0]  hdiv_q;
    logic [19:0] cal_q;
    logic        add_pend_q, sh_add_q;
    logic [14:0] sh_cnt_q;
    wire fast_tick = rise[`BCR_PIN_FAST] & (hdiv_q == `BCR_FAST_DIV);
    wire src_edge = (clksel == BCR_SRC_XTAL) ? rise[`BCR_PIN_XTAL] :
                    (clksel == BCR_SRC_RCA)  ? rise[`BCR_PIN_RCA]  :
                    (clksel == BCR_SRC_RCB)  ? rise[`BCR_PIN_RCB]  : fast_tick;
    // A sampled 32 kHz source leaves thousands of idle cycles for inserted pulses.
    wire halt     = (clksel != BCR_SRC_XTAL)
                  & (s2_q[`BCR_PIN_VBAT] | s2_q[`BCR_PIN_SHDN]);
    wire raw      = src_edge & ~halt;
    wire cal_slot = raw & (cal_q[`BCR_CAL_SLOT-1:0] == '0);
    wire cal_mask = cal_slot & (cal_q[19:`BCR_CAL_SLOT] < calm_q);
    wire sh_busy  = (sh_cnt_q != 15'h0000);
    wire sh_mask  = raw & sh_busy & ~sh_add_q;
    wire ins      = ~raw & (add_pend_q | (sh_busy & sh_add_q));
    wire pulse    = (raw & ~cal_mask & ~sh_mask) | ins;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) begin
            hdiv_q <= 5'h00; cal_q <= 20'h0_0000; add_pend_q <= 1'b0;
            sh_add_q <= 1'b0; sh_cnt_q <= 15'h0000;
        end else if (ce) begin
            if (rise[`BCR_PIN_FAST]) hdiv_q <= hdiv_q + 5'h01;
            if (raw) cal_q <= cal_q + 20'h0_0001;
            if (cal_slot & calp_q) add_pend_q <= 1'b1;
            else if (ins) add_pend_q <= 1'b0;
            if (wr_shift) begin
                sh_add_q <= hwdata[31]; sh_cnt_q <= hwdata[14:0];
            end else if (sh_mask | (ins & ~add_pend_q)) begin
                sh_cnt_q <= sh_cnt_q - 15'h0001;
            end
        end
    end

    // ==========================================================
    // Prescalers and reference clock
    logic [6:0]  apre_q, apre_rl_q;
    logic [14:0] spre_q, spre_rl_q;
    logic [5:0]  ref_cnt_q;
    logic [4:0]  ref_age_q;
    wire ck_apre  = pulse & (apre_q == 7'h00);
    wire ck_spre  = ck_apre & (spre_q == 15'h0000);
    wire [5:0] ref_top = ctl_q[`BCR_CT_REF60] ? `BCR_REF60_TOP : `BCR_REF50_TOP;
    wire ref_ok   = ctl_q[`BCR_CT_REFON] & (ref_age_q < `BCR_REF_AGE);
    wire ref_sec  = rise[`BCR_PIN_REF] & (ref_cnt_q == ref_top);
    wire sec_tick = ref_ok ? ref_sec : ck_spre;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) begin
            apre_q <= `BCR_RST_APRE; apre_rl_q <= `BCR_RST_APRE;
            spre_q <= `BCR_RST_SPRE; spre_rl_q <= `BCR_RST_SPRE;
            ref_cnt_q <= 6'h00; ref_age_q <= 5'h1F;
        end else if (ce) begin
            if (wr_presc) begin
                apre_rl_q <= hwdata[22:16]; apre_q <= hwdata[22:16];
                spre_rl_q <= hwdata[14:0]; spre_q <= hwdata[14:0];
            end else begin
                if (pulse) apre_q <= ck_apre ? apre_rl_q : apre_q - 7'h01;
                if (ref_ok & ref_sec) spre_q <= spre_rl_q;
                else if (ck_apre) spre_q <= ck_spre ? spre_rl_q : spre_q - 15'h0001;
            end
            if (rise[`BCR_PIN_REF]) begin
                ref_cnt_q <= ref_sec ? 6'h00 : ref_cnt_q + 6'h01;
                ref_age_q <= 5'h00;
            end else if (ck_apre && ref_age_q != 5'h1F) begin
                ref_age_q <= ref_age_q + 5'h01;
            end
        end
    end

    // ==========================================================
    // Calendar
    logic [7:0] sec_q, min_q, hr_q, day_q, mon_q, yr_q;
    logic [2:0] wd_q;
    logic       pm_q, tick_q;
    wire sec_wrap = (sec_q == 8'h59);
    wire min_wrap = (min_q == 8'h59);
    wire [7:0] hr_next = fmt12 ? ((hr_q == 8'h12) ? 8'h01 : bcd_inc(hr_q))
                               : ((hr_q == 8'h23) ? 8'h00 : bcd_inc(hr_q));
    wire day_roll = sec_wrap & min_wrap & (fmt12 ? (hr_q == 8'h11 & pm_q) : (hr_q == 8'h23));
    wire mon_end  = (day_q == month_len(mon_q, yr_q));
    wire [31:0] cur_time = pack_time(sec_q, min_q, hr_q, pm_q);
    wire [31:0] cur_date = pack_date(yr_q, wd_q, mon_q, day_q);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) begin
            sec_q <= 8'h00; min_q <= 8'h00; hr_q <= 8'h00; pm_q <= 1'b0; tick_q <= 1'b0;
            day_q <= `BCR_RST_DAY; mon_q <= `BCR_RST_MON; yr_q <= 8'h00; wd_q <= `BCR_RST_WDAY;
        end else if (ce) begin
            tick_q <= sec_tick;
            if (wr_time) begin
                sec_q <= {1'b0, hwdata[6:0]}; min_q <= {1'b0, hwdata[14:8]};
                hr_q <= {2'b00, hwdata[21:16]}; pm_q <= hwdata[22];
            end else if (sec_tick) begin
                sec_q <= sec_wrap ? 8'h00 : bcd_inc(sec_q);
                if (sec_wrap) min_q <= min_wrap ? 8'h00 : bcd_inc(min_q);
                if (sec_wrap & min_wrap) begin
                    hr_q <= hr_next;
                    pm_q <= pm_q ^ (fmt12 & (hr_q == 8'h11));
                end
            end
            if (wr_date) begin
                yr_q <= hwdata[23:16]; wd_q <= hwdata[15:13];
                mon_q <= {3'b000, hwdata[12:8]}; day_q <= {2'b00, hwdata[5:0]};
            end else if (sec_tick & day_roll) begin
                wd_q <= (wd_q == 3'h7) ? 3'h1 : wd_q + 3'h1;
                day_q <= mon_end ? 8'h01 : bcd_inc(day_q);
                if (mon_end) begin
                    mon_q <= (mon_q == 8'h12) ? 8'h01 : bcd_inc(mon_q);
                    if (mon_q == 8'h12) yr_q <= (yr_q == 8'h99) ? 8'h00 : bcd_inc(yr_q);
                end
            end
        end
    end

    // ==========================================================
    // Wake-up timer
    logic [3:0]  wdiv_q;
    logic [16:0] wkt_q;
    wire [3:0]  wmask  = 4'hF >> wuck[1:0];
    wire        wtick  = wuck[2] ? sec_tick : (pulse & ((wdiv_q & wmask) == wmask));
    wire [16:0] wkt_rl = {wuck[2] & wuck[1], wutr_q};
    wire        wkt_ev = ctl_q[`BCR_CT_WUTE] & wtick & (wkt_q == 17'h0_0000);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) begin
            wdiv_q <= 4'h0; wkt_q <= 17'h1_FFFF;
        end else if (ce) begin
            if (pulse) wdiv_q <= wdiv_q + 4'h1;
            if (!ctl_q[`BCR_CT_WUTE]) wkt_q <= wkt_rl;
            else if (wkt_ev) wkt_q <= wkt_rl;
            else if (wtick) wkt_q <= wkt_q - 17'h0_0001;
        end
    end

    // ==========================================================
    // Tamper filter and timestamp
    logic       act_q, tf_done_q;
    logic [3:0] tf_cnt_q;
    logic [31:0] ts_time_q, ts_date_q;
    logic [14:0] ts_ss_q;
    bcr_ev_t     flg_q;
    wire       act   = (s2_q[`BCR_PIN_TAMP] == ctl_q[`BCR_CT_TPOL]);
    wire [3:0] tf_nx = tf_cnt_q + 4'h1;
    wire [3:0] need  = 4'h1 << tflt;
    wire tamp_ev = ctl_q[`BCR_CT_TAMPE] & ((tflt == 2'b00) ? (act & ~act_q)
                 : (ck_apre & act & ~tf_done_q & (tf_nx == need)));
    wire pin_ev  = ctl_q[`BCR_CT_TSFALL] ? fall[`BCR_PIN_TS] : rise[`BCR_PIN_TS];
    wire ts_ev   = ctl_q[`BCR_CT_TSE] & (pin_ev | rise[`BCR_PIN_VBAT]
                 | (ctl_q[`BCR_CT_TAMPTS] & tamp_ev));
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) begin
            act_q <= 1'b0; tf_done_q <= 1'b0; tf_cnt_q <= 4'h0;
            ts_time_q <= 32'h0000_0000; ts_date_q <= 32'h0000_0000; ts_ss_q <= 15'h0000;
        end else if (ce) begin
            act_q <= act;
            if (!act) begin
                tf_cnt_q <= 4'h0; tf_done_q <= 1'b0;
            end else if (ck_apre & ~tf_done_q) begin
                tf_cnt_q <= tf_nx;
                tf_done_q <= (tf_nx == need);
            end
            if (ts_ev) begin
                ts_time_q <= cur_time; ts_date_q <= cur_date; ts_ss_q <= spre_q;
            end
        end
    end

    // ==========================================================
    // Event flags, interrupt and wake-up
    logic irq_q, wake_q;
    wire alra_ev = ctl_q[`BCR_CT_ALRAE] & tick_q & alarm_hit(alra_q, cur_time, day_q);
    wire alrb_ev = ctl_q[`BCR_CT_ALRBE] & tick_q & alarm_hit(alrb_q, cur_time, day_q);
    wire bcr_ev_t ev = {tamp_ev, ts_ev & flg_q[`BCR_EV_TS], ts_ev, wkt_ev, alrb_ev, alra_ev};
    // A set arriving with the clearing read survives it.
    wire bcr_ev_t flg_d = (flg_q & ~{6{rd_stat}}) | ev;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn) begin
            flg_q <= '0; irq_q <= 1'b0; wake_q <= 1'b0;
        end else if (ce) begin
            flg_q <= flg_d;
            irq_q <= |(flg_d & msk_q);
            wake_q <= |(ev & msk_q);
        end
    end
    assign irq    = irq_q;
    assign wakeup = wake_q;

    // ==========================================================
    // Read selection
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (!v_q) rd_mux = 32'h0000_0000;
        else if (a_q == `BCR_OFF_TIME) rd_mux = cur_time;
        else if (a_q == `BCR_OFF_DATE) rd_mux = cur_date;
        else if (a_q == `BCR_OFF_CTRL) rd_mux = {14'h0000, ctl_q};
        else if (a_q == `BCR_OFF_PRESC) rd_mux = {9'h000, apre_rl_q, 1'b0, spre_rl_q};
        else if (a_q == `BCR_OFF_WUTR) rd_mux = {16'h0000, wutr_q};
        else if (a_q == `BCR_OFF_ALRA) rd_mux = alra_q;
        else if (a_q == `BCR_OFF_ALRB) rd_mux = alrb_q;
        else if (a_q == `BCR_OFF_SSR) rd_mux = {17'h0_0000, spre_q};
        else if (a_q == `BCR_OFF_SHIFT) rd_mux = {sh_add_q, 16'h0000, sh_cnt_q};
        else if (a_q == `BCR_OFF_CAL) rd_mux = {16'h0000, calp_q, 6'h00, calm_q};
        else if (a_q == `BCR_OFF_STAT) rd_mux = {21'h00_0000, sh_busy, halt, ref_ok, 2'b00, flg_q};
        else if (a_q == `BCR_OFF_MASK) rd_mux = {26'h000_0000, msk_q};
        else if (a_q == `BCR_OFF_TSTIME) rd_mux = ts_time_q;
        else if (a_q == `BCR_OFF_TSDATE) rd_mux = ts_date_q;
        else if (a_q == `BCR_OFF_TSSSR) rd_mux = {17'h0_0000, ts_ss_q};
        else if (bkp_sel) rd_mux = bkp_mem[a_q[6:2]];
    end
endmodule : bcr_top

//--- verif/bcr_checker.sv
`timescale 1ns/1ps
module bcr_checker (
    input logic        hclk,
    input logic        hresetn,
    input logic        ce,
    input logic        hsel,
    input logic [31:0] haddr,
    input logic [1:0]  htrans,
    input logic        hwrite,
    input logic [2:0]  hsize,
    input logic        hready,
    input logic        hreadyout,
    input logic [31:0] hrdata,
    input logic        hresp,
    input logic        irq,
    input logic        wakeup
);
    // ==========================================================
    // Bus terms
    // The wait checks assume ce stays high through a transfer, as frozen flops stretch it.
    wire tk = hsel && htrans[1] && hready && ce;
    wire wd = tk && hsize == 3'b010;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================================
    // Properties
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("hresp left OKAY");
    one_wait_a: assert property (wd |=> !hreadyout ##1 hreadyout)
        else $error("word transfer did not take exactly one wait");
    wait_ends_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait state lasted more than one cycle");
    size_skip_a: assert property (tk && hsize != 3'b010 && hreadyout |=> hreadyout)
        else $error("non-word transfer inserted a wait");
    rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data changed outside a completion");
    unmapped_zero_a: assert property (wd && !hwrite && haddr[31:8] != 0 |-> ##2 hrdata == 0)
        else $error("out of range read not zero");
    wake_irq_a: assert property (wakeup |-> irq)
        else $error("wakeup pulse without interrupt");
    ce_freeze_a: assert property (!ce |=> $stable(hrdata) && $stable(irq))
        else $error("outputs moved while clock enable low");
endmodule : bcr_checker

//--- verif/bcr_top_bench.sv
`timescale 1ns/1ps
module bcr_top_bench;
    logic        hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, xtal = 0;
    logic        battery_mode = 0, shutdown_mode = 0, timestamp_in = 0, tamp = 0;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'b010, sz = 3'b010;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    wire         hready, hreadyout, hresp, irq, wakeup;
    int          err_count = 0, checks = 0, n, wakes = 0;
    assign hready = hreadyout;
    always #50 hclk = ~hclk;
    // Wake-up is a one-cycle pulse, so it is counted at every edge.
    always @(posedge hclk)
        if (wakeup === 1'b1) wakes++;
    bcr_top bcr_top_inst (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hrdata, .hresp, .low_speed_crystal_clock(xtal),
        .low_power_rc_clock_a(1'b0), .low_drift_rc_clock_b(1'b0),
        .high_speed_external_clock(1'b0), .ref_clock_in(1'b0), .tamper_in(tamp),
        .timestamp_in, .battery_mode, .shutdown_mode, .irq, .wakeup);
    // ==========================================================
    // Bus and checking tasks
    task automatic end_of_test;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    // Every wait is bounded so a stuck ready ends the run instead of hanging it.
    task automatic wrdy;
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end while (hready !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            err_count++;
            end_of_test;
        end
    endtask : wrdy
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= a;
        hsize  <= sz;
        wrdy;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wrdy;
        r = hrdata;
    endtask : xfer
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask : rd
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    // One crystal edge; the pin is held well below half the bus clock rate.
    task automatic tick;
        repeat (4) @(posedge hclk);
        xtal <= 1'b1;
        repeat (4) @(posedge hclk);
        xtal <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask : tick
    // ==========================================================
    // Scenarios
    task automatic t_backup;
        wr(32'h0000_0080, 32'hA5A5_1234);
        wr(32'h0000_00CC, 32'h0BAD_F00D);
        sz = 3'b000;
        wr(32'h0000_0080, 32'hFFFF_FFFF);
        sz = 3'b010;
        rd(32'h0000_0080, 32'hA5A5_1234);
        rd(32'h0000_00D0, 32'h0000_0000);
        rd(32'h0001_0080, 32'h0000_0000);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(32'h0000_0080, 32'hA5A5_1234);
        rd(32'h0000_00CC, 32'h0BAD_F00D);
        rd(32'h0000_0004, 32'h0000_2101);
        rd(32'h0000_0010, 32'h0000_FFFF);
    endtask : t_backup
    task automatic t_calendar;
        wr(32'h0000_000C, 32'h0000_0000);
        wr(32'h0000_0008, 32'h0001_0000);
        wr(32'h0000_0000, 32'h0023_5959);
        wr(32'h0000_0004, 32'h0024_6228);
        tick;
        rd(32'h0000_0000, 32'h0000_0000);
        rd(32'h0000_0004, 32'h0024_8229);
        battery_mode  <= 1'b1;
        shutdown_mode <= 1'b1;
        repeat (6) @(posedge hclk);
        rd(32'h0000_0028, 32'h0000_0008);
        rd(32'h0000_0034, 32'h0024_8229);
        wr(32'h0000_0000, 32'h0023_5959);
        tick;
        rd(32'h0000_0004, 32'h0024_A301);
        wr(32'h0000_0020, 32'h0000_0001);
        tick;
        rd(32'h0000_0000, 32'h0000_0000);
        wr(32'h0000_0020, 32'h8000_0001);
        rd(32'h0000_0000, 32'h0000_0001);
        wr(32'h0000_0008, 32'h0002_0400);
        tamp <= 1'b1;
        repeat (4) @(posedge hclk);
        rd(32'h0000_0028, 32'h0000_0020);
        tamp <= 1'b0;
        battery_mode  <= 1'b0;
        shutdown_mode <= 1'b0;
    endtask : t_calendar
    task automatic t_wake;
        wr(32'h0000_0010, 32'h0000_0002);
        wr(32'h0000_002C, 32'h0000_0004);
        wr(32'h0000_0008, 32'h0000_0048);
        n = 0;
        while (irq !== 1'b1 && n < 4)
        begin
            tick;
            n++;
        end
        if (irq !== 1'b1)
        begin
            err_count++;
            end_of_test;
        end
        rd(32'h0000_0028, 32'h0000_0004);
        for (int i = 1; i <= 3; i++)
        begin
            tick;
            chk({31'h0, irq}, {31'h0, i == 3});
        end
        chk(wakes, 32'h0000_0002);
        ce <= 1'b0;
        repeat (3) @(posedge hclk);
        ce <= 1'b1;
        @(posedge hclk);
    endtask : t_wake
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_backup;
        t_calendar;
        t_wake;
        end_of_test;
    end
endmodule : bcr_top_bench
bind bcr_top bcr_checker bcr_checker_inst (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready, .hreadyout, .hrdata, .hresp, .irq, .wakeup);
